/* hdl/realtime_counter_alarms.sv */
/*
 real-time counter with day alarm and interval alarm, register access
 protection and one combined interrupt line.
 assumes osc_input_pin is a 32.768 kHz square level (from crystal buffer or
 direct drive) already synchronous to sys_clk; register port is a plain
 strobe bus with read data one cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module realtime_counter_alarms
    import rtc_pkg::*;
#(
    parameter int ready_window_cycles = ready_cycles
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // timebase
    input  wire logic        osc_input_pin,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // interrupt
    output logic             clock_irq_line
);

    // refuse settings that the counters cannot hold
    if (ready_window_cycles < 1) begin : window_check
        $error("ready window must be at least one cycle");
    end
    if (prescale_count != 8 || sync_cycles < 1 || sync_cycles > 4) begin : width_check
        $error("prescaler or busy counter too narrow");
    end

    logic [31:0] seconds;
    logic [11:0] subsec;
    logic [2:0]  prescale;
    logic        osc_last;
    logic [19:0] day_alarm_value;
    logic [31:0] subsec_alarm_start;
    logic [31:0] alarm_count;
    logic        alarm_running;
    logic        enable;
    logic        day_alarm_irq_enable;
    logic        subsec_alarm_irq_enable;
    logic        read_valid_irq_enable;
    logic        async_read;
    logic        unlock;
    logic        day_flag;
    logic        sub_flag;
    logic        ready;
    logic        busy;
    logic [1:0]  busy_count;
    logic [31:0] ready_count;
    logic [7:0]  trim_value;
    logic [7:0]  tick_count;
    logic [4:0]  sec_in_tick;
    logic [7:0]  osc_setup;
    logic        day_match_last;

    // timebase edge and 4096 Hz step
    wire osc_rise     = osc_input_pin & ~osc_last;
    wire sub_step     = osc_rise & (prescale == 3'(prescale_count - 1));
    wire count_step   = sub_step & enable;
    wire sub_wrap     = count_step & (subsec == 12'hfff);
    wire alarm_step   = sub_step & alarm_running;
    wire alarm_wrap   = alarm_step & (alarm_count == 32'hffff_ffff);

    // register decode
    wire sel_seconds  = (reg_addr == seconds_reg);
    wire sel_subsec   = (reg_addr == subsec_reg);
    wire sel_day      = (reg_addr == day_alarm_reg);
    wire sel_subalarm = (reg_addr == subsec_alarm_reg);
    wire sel_ctrl     = (reg_addr == control_reg);
    wire sel_trim     = (reg_addr == trim_reg);
    wire sel_osc      = (reg_addr == oscillator_setup_reg);
    wire wr_ok        = reg_write & ~busy;
    wire wr_seconds   = wr_ok & sel_seconds;
    wire wr_subsec    = wr_ok & sel_subsec;
    wire wr_day       = wr_ok & sel_day & ~day_alarm_irq_enable;
    wire wr_subalarm  = wr_ok & sel_subalarm & ~subsec_alarm_irq_enable;
    wire wr_ctrl      = wr_ok & sel_ctrl;
    wire wr_trim      = wr_ok & sel_trim & unlock;
    wire wr_osc       = reg_write & sel_osc & unlock;
    wire wr_protected = wr_seconds | wr_subsec | wr_day | wr_subalarm | wr_ctrl | wr_trim;
    wire day_match    = (day_alarm_value == seconds[19:0]);
    wire counter_upd  = count_step | wr_seconds | wr_subsec;

    // prescaler and edge detector
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            osc_last <= 1'b0;
            prescale <= 3'h0;
        end else begin
            osc_last <= osc_input_pin;
            if (osc_rise) begin
                prescale <= prescale + 3'h1;
            end
        end
    end

    // seconds and sub-second counters
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            seconds <= seconds_reset;
            subsec  <= subsec_reset;
        end else begin
            if (wr_subsec) begin
                subsec <= reg_wdata[11:0];
            end else if (count_step) begin
                subsec <= subsec + 12'h001;
            end
            if (wr_seconds) begin
                seconds <= reg_wdata;
            end else if (sub_wrap) begin
                seconds <= seconds + 32'h0000_0001;
            end
        end
    end

    // 32-second tick counter
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sec_in_tick <= 5'h00;
            tick_count  <= 8'h00;
        end else if (sub_wrap) begin
            sec_in_tick <= sec_in_tick + 5'h01;
            if (sec_in_tick == 5'(tick_period_s - 1)) begin
                tick_count <= tick_count + 8'h01;
            end
        end
    end

    // interval alarm counter
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            alarm_count   <= sub_alarm_reset;
            alarm_running <= 1'b0;
        end else if (!subsec_alarm_irq_enable) begin
            alarm_running <= 1'b0;
            alarm_count   <= subsec_alarm_start;
        end else if (!alarm_running) begin
            // first alarm may lag by up to one sub-second period
            alarm_running <= sub_step;
            alarm_count   <= subsec_alarm_start;
        end else if (alarm_wrap) begin
            alarm_count <= subsec_alarm_start;
        end else if (alarm_step) begin
            alarm_count <= alarm_count + 32'h0000_0001;
        end
    end

    // write busy and synchronisation delay
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            busy       <= 1'b0;
            busy_count <= 2'h0;
        end else if (wr_protected) begin
            busy       <= 1'b1;
            busy_count <= 2'(sync_cycles - 1);
        end else if (busy) begin
            busy_count <= busy_count - 2'h1;
            if (busy_count == 2'h0) begin
                busy <= 1'b0;
            end
        end
    end

    // read-valid window
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ready       <= 1'b0;
            ready_count <= 32'h0000_0000;
        end else if (counter_upd) begin
            ready       <= 1'b1;
            ready_count <= 32'(ready_window_cycles - 1);
        end else if (ready_count != 32'h0000_0000) begin
            ready_count <= ready_count - 32'h0000_0001;
        end else if (ready && (prescale == 3'(prescale_count - 1))) begin
            ready <= 1'b0;
        end else if (wr_ctrl && !reg_wdata[ctrl_ready_bit]) begin
            ready <= 1'b0;
        end
    end

    // control, alarms, trim and flags
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            enable                  <= 1'b0;
            day_alarm_irq_enable    <= 1'b0;
            subsec_alarm_irq_enable <= 1'b0;
            read_valid_irq_enable   <= 1'b0;
            async_read              <= 1'b0;
            unlock                  <= 1'b0;
            day_flag                <= 1'b0;
            sub_flag                <= 1'b0;
            day_alarm_value         <= day_alarm_reset;
            subsec_alarm_start      <= sub_alarm_reset;
            trim_value              <= 8'h00;
            osc_setup               <= 8'h00;
            day_match_last          <= 1'b0;
        end else begin
            day_match_last <= day_match;
            if (wr_ctrl) begin
                if (unlock) begin
                    enable <= reg_wdata[ctrl_enable_bit];
                end
                day_alarm_irq_enable    <= reg_wdata[ctrl_day_irq_en_bit];
                subsec_alarm_irq_enable <= reg_wdata[ctrl_sub_irq_en_bit];
                read_valid_irq_enable   <= reg_wdata[ctrl_ready_ie_bit];
                async_read              <= reg_wdata[ctrl_async_read_bit];
                unlock                  <= reg_wdata[ctrl_unlock_bit];
            end
            // hardware set wins over a software write in the same cycle
            if (day_match && !day_match_last) begin
                day_flag <= 1'b1;
            end else if (wr_ctrl) begin
                day_flag <= reg_wdata[ctrl_day_flag_bit];
            end
            if (alarm_wrap) begin
                sub_flag <= 1'b1;
            end else if (wr_ctrl) begin
                sub_flag <= reg_wdata[ctrl_sub_flag_bit];
            end
            if (wr_day) begin
                day_alarm_value <= reg_wdata[19:0];
            end
            if (wr_subalarm) begin
                subsec_alarm_start <= reg_wdata;
            end
            if (wr_trim) begin
                trim_value <= reg_wdata[trim_value_lsb +: 8];
            end
            if (wr_osc) begin
                osc_setup <= reg_wdata[7:0];
            end
        end
    end

    // read data mux
    wire [31:0] ctrl_view = {16'h0000, unlock, async_read, 6'h00, sub_flag, day_flag,
                             read_valid_irq_enable, ready, busy, subsec_alarm_irq_enable,
                             day_alarm_irq_enable, enable};
    wire [31:0] read_mux  = sel_seconds  ? seconds :
                            sel_subsec   ? {20'h0_0000, subsec} :
                            sel_day      ? {12'h000, day_alarm_value} :
                            sel_subalarm ? subsec_alarm_start :
                            sel_ctrl     ? ctrl_view :
                            sel_trim     ? {16'h0000, tick_count, trim_value} :
                            sel_osc      ? {24'h00_0000, osc_setup} : 32'h0000_0000;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            reg_rdata <= read_mux;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // combined interrupt
    assign clock_irq_line = (day_flag & day_alarm_irq_enable) |
                            (sub_flag & subsec_alarm_irq_enable) |
                            (ready & read_valid_irq_enable);

    // rule checks
    rollover_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        sub_wrap && !wr_seconds |=> seconds == $past(seconds) + 32'h1) else $error("seconds missed rollover");
    subsec_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        count_step && !wr_subsec |=> subsec == $past(subsec) + 12'h1) else $error("subsec step wrong");
    freeze_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !enable && !wr_subsec && !wr_seconds |=> $stable(subsec) && $stable(seconds)) else $error("counter moved");
    ready_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        count_step |=> ready) else $error("ready not set");
    busy_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_protected |=> busy [*3] ##1 !busy || $past(wr_protected)) else $error("busy timing");
    busy_block_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        busy && reg_write && sel_day |=> $stable(day_alarm_value)) else $error("write while busy");
    trim_lock_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !unlock |=> $stable(trim_value)) else $error("trim written locked");
    day_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        day_match && !day_match_last |=> day_flag) else $error("day flag missed");
    reload_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        alarm_wrap && subsec_alarm_irq_enable |=> sub_flag && alarm_count == $past(subsec_alarm_start))
        else $error("interval reload wrong");
    irq_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ready && read_valid_irq_enable |-> clock_irq_line) else $error("irq missing");
    tick_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        sub_wrap && sec_in_tick == 5'(tick_period_s - 1) |=> tick_count == $past(tick_count) + 8'h01)
        else $error("tick count missed");
    ready_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ready && ready_count != 32'h0000_0000 |=> ready) else $error("ready dropped early");
    ready_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ready && ready_count == 32'h0000_0000 && prescale == 3'(prescale_count - 1) && !counter_upd
        |=> !ready) else $error("ready held over update");
    alarm_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        alarm_step && !alarm_wrap && subsec_alarm_irq_enable |=> alarm_count == $past(alarm_count) + 32'h1)
        else $error("interval count wrong");
    alarm_arm_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        subsec_alarm_irq_enable && !alarm_running && !sub_step |=> !alarm_running) else $error("interval armed early");
    alarm_stop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !subsec_alarm_irq_enable |=> !alarm_running && alarm_count == $past(subsec_alarm_start))
        else $error("interval not reloaded");
    day_irq_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        day_flag && day_alarm_irq_enable |-> clock_irq_line) else $error("day irq missing");
    sub_irq_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        sub_flag && subsec_alarm_irq_enable |-> clock_irq_line) else $error("interval irq missing");
    enable_lock_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_ctrl && !unlock |=> $stable(enable)) else $error("enable written locked");
    rdata_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !reg_read |=> reg_rdata == 32'h0000_0000) else $error("read data not idle");

endmodule
`default_nettype wire

/* hdl/rtc_pkg.sv */
/*
 package for the real-time counter block: register offsets, field positions,
 reset values and timing counts. assumes a 50 MHz system clock.
*/
`default_nettype none
package rtc_pkg;
    // register byte offsets
    localparam logic [7:0] seconds_reg         = 8'h00;
    localparam logic [7:0] subsec_reg          = 8'h04;
    localparam logic [7:0] day_alarm_reg       = 8'h08;
    localparam logic [7:0] subsec_alarm_reg    = 8'h0c;
    localparam logic [7:0] control_reg         = 8'h10;
    localparam logic [7:0] trim_reg            = 8'h14;
    localparam logic [7:0] oscillator_setup_reg = 8'h18;

    // control register field positions
    localparam int ctrl_enable_bit      = 0;
    localparam int ctrl_day_irq_en_bit  = 1;
    localparam int ctrl_sub_irq_en_bit  = 2;
    localparam int ctrl_busy_bit        = 3;
    localparam int ctrl_ready_bit       = 4;
    localparam int ctrl_ready_ie_bit    = 5;
    localparam int ctrl_day_flag_bit    = 6;
    localparam int ctrl_sub_flag_bit    = 7;
    localparam int ctrl_async_read_bit  = 14;
    localparam int ctrl_unlock_bit      = 15;

    // trim register field positions
    localparam int trim_value_lsb       = 0;
    localparam int trim_tick_lsb        = 8;

    // reset values
    localparam logic [31:0] seconds_reset  = 32'h0000_0000;
    localparam logic [11:0] subsec_reset   = 12'h000;
    localparam logic [19:0] day_alarm_reset = 20'h0_0000;
    localparam logic [31:0] sub_alarm_reset = 32'h0000_0000;

    // timing: system clock and 32 kHz timebase
    localparam int    sys_clk_hz       = 50_000_000;
    localparam int    timebase_hz      = 32_768;
    localparam int    subsec_hz        = 4_096;
    localparam int    prescale_count   = timebase_hz / subsec_hz;
    localparam int    ready_window_us  = 120;
    localparam int    ready_cycles     = (ready_window_us * (sys_clk_hz / 1_000_000));
    localparam int    sync_cycles      = 3;
    localparam int    tick_period_s    = 32;
endpackage
`default_nettype wire

/* test/realtime_counter_alarms_test.sv */
/*
 self-checking bench for the real-time counter block: access protection, counting,
 both alarms, read-valid window and the interrupt line.
 assumes rtc_pkg and the design are compiled first; the bench drives all ports itself.
*/
`timescale 1ns/1ps
`default_nettype none
module realtime_counter_alarms_test
    import rtc_pkg::*;
;
    localparam logic [31:0] all_b    = 32'hffff_ffff;
    localparam logic [31:0] en_b     = 32'h1 << ctrl_enable_bit;
    localparam logic [31:0] day_en_b = 32'h1 << ctrl_day_irq_en_bit;
    localparam logic [31:0] sub_en_b = 32'h1 << ctrl_sub_irq_en_bit;
    localparam logic [31:0] busy_b   = 32'h1 << ctrl_busy_bit;
    localparam logic [31:0] rdy_b    = 32'h1 << ctrl_ready_bit;
    localparam logic [31:0] rdy_en_b = 32'h1 << ctrl_ready_ie_bit;
    localparam logic [31:0] day_f_b  = 32'h1 << ctrl_day_flag_bit;
    localparam logic [31:0] sub_f_b  = 32'h1 << ctrl_sub_flag_bit;
    localparam logic [31:0] async_b  = 32'h1 << ctrl_async_read_bit;
    localparam logic [31:0] unlk_b   = 32'h1 << ctrl_unlock_bit;
    localparam logic [31:0] ctl_m    = ~(busy_b | rdy_b | day_f_b);

    logic        sys_clk;
    logic        sys_rst;
    logic        osc_input_pin;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [31:0] reg_rdata;
    logic        clock_irq_line;
    logic [31:0] exp_q[$];
    logic [31:0] mask_q[$];
    logic        read_d = 1'b0;
    logic [31:0] ctl;
    logic [31:0] seed;
    int          error_cnt;
    int          checks;
    int          k;

    realtime_counter_alarms #(.ready_window_cycles(4)) realtime_counter_alarms_i (
        .sys_clk        (sys_clk),
        .sys_rst        (sys_rst),
        .osc_input_pin  (osc_input_pin),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_write      (reg_write),
        .reg_read       (reg_read),
        .reg_rdata      (reg_rdata),
        .clock_irq_line (clock_irq_line)
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input int gap);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        repeat (gap) @(posedge sys_clk);
    endtask

    // expectation is queued with the strobe; the monitor compares one cycle later
    task automatic rd(input logic [7:0] a, input logic [31:0] want, input logic [31:0] m);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        exp_q.push_back(want & m);
        mask_q.push_back(m);
        @(posedge sys_clk);
        reg_read <= 1'b0;
    endtask

    task automatic wctl(input logic [31:0] v);
        ctl = v;
        wr(control_reg, v, 4);
    endtask

    // n rising edges of the timebase, then time for the update to land
    task automatic edges(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            osc_input_pin <= 1'b1;
            repeat (2) @(posedge sys_clk);
            osc_input_pin <= 1'b0;
            @(posedge sys_clk);
        end
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic irq_is(input logic want);
        @(negedge sys_clk);
        check({31'h0, clock_irq_line}, {31'h0, want});
    endtask

    always @(posedge sys_clk) begin
        if (read_d) begin
            check(reg_rdata & mask_q.pop_front(), exp_q.pop_front());
        end
        read_d <= reg_read;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        $display("ERROR %0t: watchdog expired", $time);
        print_verdict();
    end

    initial begin
        sys_rst       = 1'b1;
        osc_input_pin = 1'b0;
        reg_addr      = 8'h00;
        reg_wdata     = 32'h0;
        reg_write     = 1'b0;
        reg_read      = 1'b0;
        seed          = 32'h0001_48b0;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (k = 0; k <= 32'h1c; k += 4) begin
            rd(8'(k), 32'h0, (8'(k) == control_reg) ? ~day_f_b : all_b);
        end
        wr(8'h40, all_b, 4);
        rd(8'h40, 32'h0, all_b);
        $display("reset and unmapped test done");

        wr(control_reg, en_b, 4);
        rd(control_reg, 32'h0, ctl_m);
        wr(trim_reg, 32'h5a, 4);
        rd(trim_reg, 32'h0, 32'hff);
        wr(control_reg, unlk_b | async_b, 0);
        ctl = unlk_b | async_b;
        rd(control_reg, ctl | busy_b, ~(rdy_b | day_f_b));
        seed = xorshift(seed);
        wr(trim_reg, seed, 0);
        wr(day_alarm_reg, 32'h123, 4);
        rd(trim_reg, seed, 32'hff);
        rd(day_alarm_reg, 32'h0, all_b);
        rd(control_reg, ctl, ~(rdy_b | day_f_b));
        seed = xorshift(seed);
        wr(oscillator_setup_reg, seed, 4);
        rd(oscillator_setup_reg, seed, 32'hff);
        $display("access protection test done");

        wctl(unlk_b | en_b);
        edges(24);
        rd(subsec_reg, 32'h3, all_b);
        wr(seconds_reg, 32'h0fff_ffff, 4);
        wr(subsec_reg, 32'hfff, 4);
        edges(8);
        rd(seconds_reg, 32'h1000_0000, all_b);
        rd(subsec_reg, 32'h0, all_b);
        wctl(unlk_b);
        edges(16);
        rd(subsec_reg, 32'h0, all_b);
        rd(seconds_reg, 32'h1000_0000, all_b);
        $display("counting test done");

        wctl(unlk_b | en_b);
        wr(day_alarm_reg, 32'h1, 4);
        wctl(unlk_b | en_b | day_en_b);
        rd(day_alarm_reg, 32'h1, all_b);
        irq_is(1'b0);
        wr(subsec_reg, 32'hfff, 4);
        edges(8);
        rd(control_reg, ctl | day_f_b, ~(busy_b | rdy_b));
        irq_is(1'b1);
        wctl(unlk_b | en_b | day_en_b);
        edges(8);
        rd(control_reg, ctl, ~(busy_b | rdy_b));
        irq_is(1'b0);
        wctl(unlk_b | en_b | day_en_b | day_f_b);
        irq_is(1'b1);
        wctl(unlk_b | en_b | day_f_b);
        irq_is(1'b0);
        $display("day alarm test done");

        wctl(unlk_b | en_b);
        wr(subsec_alarm_reg, 32'hffff_fffe, 4);
        wctl(unlk_b | en_b | sub_en_b);
        k = 0;
        while (clock_irq_line !== 1'b1 && k < 3) begin
            edges(8);
            k++;
        end
        irq_is(1'b1);
        wctl(unlk_b | en_b | sub_en_b);
        edges(8);
        irq_is(1'b0);
        edges(8);
        irq_is(1'b1);
        rd(control_reg, ctl | sub_f_b, ctl_m | sub_f_b);
        wctl(unlk_b | en_b);
        wr(subsec_alarm_reg, 32'h0, 4);
        wctl(unlk_b | en_b | sub_en_b);
        edges(24);
        irq_is(1'b0);
        $display("interval alarm test done");

        wctl(unlk_b | en_b | rdy_en_b);
        rd(control_reg, ctl, ~busy_b);
        irq_is(1'b0);
        edges(8);
        rd(control_reg, ctl | rdy_b, ~busy_b);
        irq_is(1'b1);
        edges(7);
        rd(control_reg, ctl, ~busy_b);
        edges(1);
        rd(control_reg, ctl | rdy_b, ~busy_b);
        $display("read-valid test done");
        wctl(unlk_b | en_b | async_b);
        rd(control_reg, ctl, ~(busy_b | rdy_b));
        rd(seconds_reg, 32'h1000_0001, all_b);
        rd(seconds_reg, 32'h1000_0001, all_b);
        rd(subsec_reg, 32'h0000_000b, all_b);
        rd(subsec_reg, 32'h0000_000b, all_b);
        $display("async read test done");
        repeat (4) @(posedge sys_clk);
        print_verdict();
    end
endmodule
`default_nettype wire
